// ---- logic/uucd_consts.svh ----
// constants for the usb uart control request decoder
// assumes setup packets arrive little endian, byte 0 in bits 7:0
`ifndef UUCD_CONSTS_SVH
`define UUCD_CONSTS_SVH

`define UUCD_RT_DEV_IN   8'h80
`define UUCD_RT_IF_IN    8'h81
`define UUCD_RT_EP_IN    8'h82
`define UUCD_RT_DEV_OUT  8'h00
`define UUCD_RT_EP_OUT   8'h02
`define UUCD_RT_CLS_OUT  8'h21
`define UUCD_RT_CLS_IN   8'ha1
`define UUCD_RT_VND_OUT  8'h40
`define UUCD_RT_VND_IN   8'hc0

`define UUCD_RQ_GET_STATUS 8'h00
`define UUCD_RQ_CLR_FEAT   8'h01
`define UUCD_RQ_SET_FEAT   8'h03
`define UUCD_RQ_SET_ADDR   8'h05
`define UUCD_RQ_GET_DESC   8'h06
`define UUCD_RQ_GET_CFG    8'h08
`define UUCD_RQ_SET_CFG    8'h09
`define UUCD_RQ_GET_IF     8'h0a
`define UUCD_RQ_SET_LC     8'h20
`define UUCD_RQ_GET_LC     8'h21
`define UUCD_RQ_SET_CLS    8'h22
`define UUCD_RQ_BREAK      8'h23
`define UUCD_RQ_REG_WR     8'h00
`define UUCD_RQ_REG_RD     8'h01

`define UUCD_FEAT_HALT 16'h0000
`define UUCD_FEAT_WAKE 16'h0001
`define UUCD_FEAT_TEST 16'h0002

`define UUCD_EP0   8'h00
`define UUCD_EP1   8'h01
`define UUCD_EP81  8'h81
`define UUCD_EP85  8'h85

`define UUCD_DESC_DEV 8'h01
`define UUCD_DESC_STR 8'h03

`define UUCD_LC_LEN     3'd7
`define UUCD_LC_LEN16   16'h0007
`define UUCD_STAT_LEN   3'd2
`define UUCD_ONE_LEN    3'd1
`define UUCD_STOP_ONE   8'h00
`define UUCD_STOP_TWO   8'h02
`define UUCD_PAR_MAX    8'h04
`define UUCD_BITS_7     8'h07
`define UUCD_BITS_9     8'h09

`define UUCD_CLS_DTR 0
`define UUCD_CLS_RTS 1

`define UUCD_REG_ERR_STAT  12'hc09
`define UUCD_REG_TX_BREAK  12'hc0a
`define UUCD_REG_PIN_SET   12'hc0e
`define UUCD_REG_PIN_CLR   12'hc0f

`define UUCD_OFF_CTRL    8'h00
`define UUCD_OFF_STATUS  8'h04
`define UUCD_OFF_RATE    8'h08
`define UUCD_OFF_FMT     8'h0c
`define UUCD_OFF_BREAK   8'h10
`define UUCD_OFF_LINES   8'h14

`define UUCD_CTRL_SELFPWR 0
`define UUCD_CTRL_DEC_EN  1
`define UUCD_STAT_UNSAFE  13

`define UUCD_LC_RATE_RST 32'h0000_2580
`define UUCD_LC_BITS_RST 8'h08

`endif

// ---- logic/uucd_pkg.sv ----
// types shared by the control request decoder files
// assumes nothing beyond the constants header
package uucd_pkg;
  typedef enum logic [4:0] {
    K_BAD, K_DEV_STATUS, K_IF_STATUS, K_EP_STATUS, K_CLR_WAKE,
    K_CLR_HALT, K_SET_WAKE, K_TEST_MODE, K_SET_HALT, K_SET_ADDR,
    K_GET_DESC, K_GET_CFG, K_SET_CFG, K_GET_IF, K_SET_LC, K_GET_LC,
    K_SET_CLS, K_BREAK, K_REG_WR, K_REG_RD
  } uucd_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_OUT, ST_RDWAIT, ST_IN
  } uucd_state_t;
endpackage : uucd_pkg

// ---- logic/uucd_setup_if.sv ----
// decoded setup packet fields passed from the decoder to the top
// assumes the decoder drives every field combinationally
`timescale 1ns/1ps
interface uucd_setup_if;
  logic [15:0]          value;
  logic [15:0]          index;
  logic [15:0]          length;
  uucd_pkg::uucd_kind_t kind;
  modport dec (output value, output index, output length, output kind);
  modport sink (input value, input index, input length, input kind);
endinterface : uucd_setup_if

// ---- logic/uucd_setup_dec.sv ----
// classifies one eight byte setup packet into a request kind
// assumes the packet is stable while the top samples it
`timescale 1ns/1ps
`include "uucd_consts.svh"
module uucd_setup_dec (
  input wire logic [63:0] setup_pkt,
  uucd_setup_if.dec       sp
);
  import uucd_pkg::*;

  wire [7:0]  rt = setup_pkt[7:0];
  wire [7:0]  rq = setup_pkt[15:8];
  wire [15:0] vl = setup_pkt[31:16];
  wire [15:0] ix = setup_pkt[47:32];

  wire ix_hi0   = (ix[15:8] == 8'h00);
  wire ep_any   = ix_hi0 && (ix[7:0] == `UUCD_EP0 || ix[7:0] == `UUCD_EP1 ||
                  ix[7:0] == `UUCD_EP81 || ix[7:0] == `UUCD_EP85);
  wire ep_halt  = ep_any && (ix[7:0] != `UUCD_EP0);
  wire if_ok    = (ix[15:1] == 15'h0000);
  wire desc_ok  = (vl[15:8] >= `UUCD_DESC_DEV) && (vl[15:8] <= `UUCD_DESC_STR);
  wire cfg_ok   = (vl[15:1] == 15'h0000);
  wire d_in     = (rt == `UUCD_RT_DEV_IN);
  wire d_out    = (rt == `UUCD_RT_DEV_OUT);
  wire c_out    = (rt == `UUCD_RT_CLS_OUT);

  assign sp.value  = vl;
  assign sp.index  = ix;
  assign sp.length = setup_pkt[63:48];

  // three groups: standard, abstract control class, vendor register access
  assign sp.kind =
    (d_in && rq == `UUCD_RQ_GET_STATUS)                     ? K_DEV_STATUS :
    (rt == `UUCD_RT_IF_IN && rq == `UUCD_RQ_GET_STATUS && if_ok)
                                                            ? K_IF_STATUS :
    (rt == `UUCD_RT_EP_IN && rq == `UUCD_RQ_GET_STATUS && ep_any)
                                                            ? K_EP_STATUS :
    (d_out && rq == `UUCD_RQ_CLR_FEAT && vl == `UUCD_FEAT_WAKE)
                                                            ? K_CLR_WAKE :
    (rt == `UUCD_RT_EP_OUT && rq == `UUCD_RQ_CLR_FEAT &&
     vl == `UUCD_FEAT_HALT && ep_any)                       ? K_CLR_HALT :
    (d_out && rq == `UUCD_RQ_SET_FEAT && vl == `UUCD_FEAT_WAKE)
                                                            ? K_SET_WAKE :
    (d_out && rq == `UUCD_RQ_SET_FEAT && vl == `UUCD_FEAT_TEST)
                                                            ? K_TEST_MODE :
    (rt == `UUCD_RT_EP_OUT && rq == `UUCD_RQ_SET_FEAT &&
     vl == `UUCD_FEAT_HALT && ep_halt)                      ? K_SET_HALT :
    (d_out && rq == `UUCD_RQ_SET_ADDR)                      ? K_SET_ADDR :
    (d_in && rq == `UUCD_RQ_GET_DESC && desc_ok)            ? K_GET_DESC :
    (d_in && rq == `UUCD_RQ_GET_CFG)                        ? K_GET_CFG :
    (d_out && rq == `UUCD_RQ_SET_CFG && cfg_ok)             ? K_SET_CFG :
    (rt == `UUCD_RT_IF_IN && rq == `UUCD_RQ_GET_IF && if_ok) ? K_GET_IF :
    (c_out && rq == `UUCD_RQ_SET_LC)                        ? K_SET_LC :
    (rt == `UUCD_RT_CLS_IN && rq == `UUCD_RQ_GET_LC)        ? K_GET_LC :
    (c_out && rq == `UUCD_RQ_SET_CLS)                       ? K_SET_CLS :
    (c_out && rq == `UUCD_RQ_BREAK)                         ? K_BREAK :
    (rt == `UUCD_RT_VND_OUT && rq == `UUCD_RQ_REG_WR)       ? K_REG_WR :
    (rt == `UUCD_RT_VND_IN && rq == `UUCD_RQ_REG_RD)        ? K_REG_RD :
                                                              K_BAD;
endmodule : uucd_setup_dec

// ---- logic/uucd_top.sv ----
// endpoint zero control request decoder of a usb uart bridge
// assumes a usb engine on pclk hands over setup packets and data bytes
//
// Behaviour
// - device status returns two bytes: remote wakeup and self powered
// - set feature selector two starts factory test mode, host avoids it
// - set line coding takes a seven byte host to device data stage
// - get line coding returns the current seven byte structure
// - send break starts a break, duration from the value field
// - set control line state updates modem outputs from value bitmap
// - line coding bytes zero to three are little endian bit rate
// - stop byte: zero one stop bit, two the other, 1.5 refused
// - parity byte: none, odd, even, mark, space as codes 0 to 4
// - data bits byte must be seven, eight or nine
// - value bit zero drives terminal ready, bits 15 to 2 reserved
// - value bit one drives request to send
// - request to send bit ignored while in full duplex mode
// - vendor write and read reach 12-bit registers, address in index
// - pin set, pin clear, break, error status writable while enabled
// - decoder accepts standard, class and vendor register requests
`timescale 1ns/1ps
`include "uucd_consts.svh"
module uucd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        setup_valid,
  input  wire logic [63:0] setup_pkt,
  input  wire logic        out_valid,
  input  wire logic [7:0]  out_data,
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic [7:0]       in_data,
  output logic             ep0_stall,
  output logic             xfer_done,
  input  wire logic        half_duplex,
  input  wire logic        driver_active,
  input  wire logic        uart_enabled,
  input  wire logic [11:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [11:0]      reg_addr,
  output logic [11:0]      reg_wdata,
  output logic [6:0]       dev_addr,
  output logic             configured,
  output logic             remote_wake,
  output logic [2:0]       ep_halt,
  output logic             test_go,
  output logic [7:0]       test_sel,
  output logic             desc_req,
  output logic [15:0]      desc_value,
  output logic [15:0]      desc_len,
  output logic             dtr,
  output logic             rts,
  output logic             brk_go,
  output logic [15:0]      brk_len,
  output logic [31:0]      lc_rate,
  output logic [7:0]       lc_stop,
  output logic [7:0]       lc_parity,
  output logic [7:0]       lc_bits,
  output logic             lc_mirror_load
);
  import uucd_pkg::*;

  uucd_setup_if sp ();

  uucd_setup_dec u_dec (
    .setup_pkt (setup_pkt),
    .sp        (sp)
  );

  uucd_state_t      state;
  uucd_state_t      next_state;
  uucd_kind_t       kind_q;
  logic [15:0]      value_q;
  logic [15:0]      index_q;
  logic [15:0]      length_q;
  logic [6:0][7:0]  resp;
  logic [2:0]       resp_len;
  logic [2:0]       ptr;
  logic [5:0][7:0]  lc_buf;
  logic [2:0]       out_cnt;
  logic             self_powered;
  logic             dec_en;
  logic             unsafe_wr;

  // ---- request execution decode
  wire exec      = (state == ST_EXEC);
  wire rdwait    = (state == ST_RDWAIT);
  wire in_take   = (state == ST_IN) && in_valid && in_ready;
  wire in_last   = in_take && (ptr == resp_len - 3'd1);
  wire lc_last   = (state == ST_OUT) && out_valid &&
                   (out_cnt == `UUCD_LC_LEN - 3'd1);
  wire lc_len_ok = (length_q == `UUCD_LC_LEN16);
  wire bad_exec  = exec && (kind_q == K_BAD ||
                   (kind_q == K_SET_LC && !lc_len_ok));

  // natural answer length, cut to what the host asked for
  wire [2:0] nat_len =
    (kind_q == K_DEV_STATUS || kind_q == K_IF_STATUS ||
     kind_q == K_EP_STATUS || kind_q == K_REG_RD) ? `UUCD_STAT_LEN :
    (kind_q == K_GET_CFG || kind_q == K_GET_IF)   ? `UUCD_ONE_LEN :
    (kind_q == K_GET_LC)                          ? `UUCD_LC_LEN : 3'd0;
  wire [2:0] tx_len = (length_q < {13'h0000, nat_len}) ?
                      length_q[2:0] : nat_len;

  wire ep_halted =
    (index_q[7:0] == `UUCD_EP1)  ? ep_halt[0] :
    (index_q[7:0] == `UUCD_EP81) ? ep_halt[1] :
    (index_q[7:0] == `UUCD_EP85) ? ep_halt[2] : 1'b0;

  wire [7:0] dev_stat = {6'h00, remote_wake, self_powered};

  wire [55:0] next_resp =
    (kind_q == K_DEV_STATUS) ? {48'h0, dev_stat} :
    (kind_q == K_EP_STATUS)  ? {48'h0, 7'h00, ep_halted} :
    (kind_q == K_GET_CFG)    ? {48'h0, 7'h00, configured} :
    (kind_q == K_GET_LC)     ? {lc_bits, lc_parity, lc_stop,
                                lc_rate} :
                               56'h0;

  wire in_kind   = (tx_len != 3'd0) && (kind_q != K_REG_RD);
  wire local_end = exec && !bad_exec && !in_kind && kind_q != K_REG_RD &&
                   kind_q != K_SET_LC && kind_q != K_GET_DESC;

  // ---- line coding check on the last data byte
  wire [7:0] lc_stop_in = lc_buf[4];
  wire [7:0] lc_par_in  = lc_buf[5];
  wire stop_ok = (lc_stop_in == `UUCD_STOP_ONE) ||
                 (lc_stop_in == `UUCD_STOP_TWO);
  wire par_ok  = (lc_par_in <= `UUCD_PAR_MAX);
  wire bits_ok = (out_data >= `UUCD_BITS_7) &&
                 (out_data <= `UUCD_BITS_9);
  wire lc_ok   = stop_ok && par_ok && bits_ok;

  wire done_evt  = local_end || (lc_last && lc_ok) || in_last ||
                   (rdwait && resp_len == 3'd0);
  wire stall_evt = bad_exec || (lc_last && !lc_ok);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = ST_IDLE;
      ST_EXEC: begin
        if (bad_exec)
          next_state = ST_IDLE;
        else if (kind_q == K_REG_RD)
          next_state = ST_RDWAIT;
        else if (kind_q == K_SET_LC)
          next_state = ST_OUT;
        else if (in_kind)
          next_state = ST_IN;
        else
          next_state = ST_IDLE;
      end
      ST_OUT:    next_state = lc_last ? ST_IDLE : ST_OUT;
      ST_RDWAIT: next_state = (resp_len != 3'd0) ? ST_IN : ST_IDLE;
      ST_IN:     next_state = in_last ? ST_IDLE : ST_IN;
      default:   next_state = ST_IDLE;
    endcase
    // a new setup always aborts whatever transfer is running
    if (setup_valid)
      next_state = ST_EXEC;
  end

  // ---- setup capture; disabled decoder turns every request into a stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      kind_q   <= K_BAD;
      value_q  <= 16'h0000;
      index_q  <= 16'h0000;
      length_q <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      if (setup_valid) begin
        kind_q   <= dec_en ? sp.kind : K_BAD;
        value_q  <= sp.value;
        index_q  <= sp.index;
        length_q <= sp.length;
      end
    end
  end

  // ---- data stages towards and from the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp      <= 56'h0;
      resp_len  <= 3'd0;
      ptr       <= 3'd0;
      in_valid  <= 1'b0;
      in_data   <= 8'h00;
      out_cnt   <= 3'd0;
      lc_buf    <= 48'h0;
      ep0_stall <= 1'b0;
      xfer_done <= 1'b0;
    end else if (ce) begin
      xfer_done <= done_evt && !setup_valid;
      if (setup_valid)
        ep0_stall <= 1'b0;
      else if (stall_evt)
        ep0_stall <= 1'b1;
      if (setup_valid) begin
        in_valid <= 1'b0;
      end else if (exec) begin
        resp     <= next_resp;
        resp_len <= tx_len;
        ptr      <= 3'd0;
        out_cnt  <= 3'd0;
        in_data  <= next_resp[7:0];
        in_valid <= in_kind && !bad_exec;
      end else if (rdwait) begin
        resp     <= {44'h0, reg_rdata};
        in_data  <= reg_rdata[7:0];
        in_valid <= (resp_len != 3'd0);
      end else if (in_take) begin
        if (in_last) begin
          in_valid <= 1'b0;
        end else begin
          ptr     <= ptr + 3'd1;
          in_data <= resp[ptr + 3'd1];
        end
      end else if (state == ST_OUT && out_valid && !lc_last) begin
        lc_buf[out_cnt] <= out_data;
        out_cnt         <= out_cnt + 3'd1;
      end
    end
  end

  // ---- standard device state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_addr    <= 7'h00;
      configured  <= 1'b0;
      remote_wake <= 1'b0;
      ep_halt     <= 3'b000;
      test_go     <= 1'b0;
      test_sel    <= 8'h00;
      desc_req    <= 1'b0;
      desc_value  <= 16'h0000;
      desc_len    <= 16'h0000;
    end else if (ce) begin
      test_go  <= exec && kind_q == K_TEST_MODE;
      desc_req <= exec && kind_q == K_GET_DESC;
      if (exec) begin
        case (kind_q)
          K_SET_ADDR: dev_addr <= value_q[6:0];
          K_SET_CFG: begin
            configured <= value_q[0];
            ep_halt    <= 3'b000;
          end
          K_SET_WAKE: remote_wake <= 1'b1;
          K_CLR_WAKE: remote_wake <= 1'b0;
          K_SET_HALT, K_CLR_HALT: begin
            if (index_q[7:0] == `UUCD_EP1)
              ep_halt[0] <= (kind_q == K_SET_HALT);
            if (index_q[7:0] == `UUCD_EP81)
              ep_halt[1] <= (kind_q == K_SET_HALT);
            if (index_q[7:0] == `UUCD_EP85)
              ep_halt[2] <= (kind_q == K_SET_HALT);
          end
          K_TEST_MODE: test_sel <= index_q[15:8];
          K_GET_DESC: begin
            desc_value <= value_q;
            desc_len   <= length_q;
          end
          default: ;
        endcase
      end
    end
  end

  // ---- serial side: class requests and vendor register access
  wire reg_exempt = (index_q[11:0] == `UUCD_REG_PIN_SET) ||
                    (index_q[11:0] == `UUCD_REG_PIN_CLR) ||
                    (index_q[11:0] == `UUCD_REG_TX_BREAK) ||
                    (index_q[11:0] == `UUCD_REG_ERR_STAT);
  wire ex_reg_wr  = exec && kind_q == K_REG_WR;
  wire ex_reg_rd  = exec && kind_q == K_REG_RD;
  // flags writes the host should have made with the serial port disabled
  wire unsafe_set = ex_reg_wr && uart_enabled && !reg_exempt;
  wire apb_wr     = psel && penable && pwrite;
  wire unsafe_clr = apb_wr && paddr == `UUCD_OFF_STATUS &&
                    pwdata[`UUCD_STAT_UNSAFE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr            <= 1'b0;
      rts            <= 1'b0;
      brk_go         <= 1'b0;
      brk_len        <= 16'h0000;
      reg_wr         <= 1'b0;
      reg_rd         <= 1'b0;
      reg_addr       <= 12'h000;
      reg_wdata      <= 12'h000;
      unsafe_wr      <= 1'b0;
      lc_rate        <= `UUCD_LC_RATE_RST;
      lc_stop        <= `UUCD_STOP_ONE;
      lc_parity      <= 8'h00;
      lc_bits        <= `UUCD_LC_BITS_RST;
      lc_mirror_load <= 1'b0;
    end else if (ce) begin
      brk_go         <= exec && kind_q == K_BREAK;
      reg_wr         <= ex_reg_wr;
      reg_rd         <= ex_reg_rd;
      // set wins over a software clear in the same cycle
      unsafe_wr      <= unsafe_set || (unsafe_wr && !unsafe_clr);
      lc_mirror_load <= lc_last && lc_ok && !driver_active;
      if (exec && kind_q == K_BREAK)
        brk_len <= value_q;
      if (exec && kind_q == K_SET_CLS) begin
        dtr <= value_q[`UUCD_CLS_DTR];
        if (half_duplex)
          rts <= value_q[`UUCD_CLS_RTS];
      end
      if (ex_reg_wr || ex_reg_rd)
        reg_addr <= index_q[11:0];
      if (ex_reg_wr)
        reg_wdata <= value_q[11:0];
      if (lc_last && lc_ok) begin
        lc_rate   <= {lc_buf[3], lc_buf[2], lc_buf[1], lc_buf[0]};
        lc_stop   <= lc_stop_in;
        lc_parity <= lc_par_in;
        lc_bits   <= out_data;
      end
    end
  end

  // ---- apb slave, zero wait states; read data prepared in setup phase
  wire apb_setup = psel && !penable;
  wire hit_ctrl  = (paddr == `UUCD_OFF_CTRL);
  wire addr_ok   = hit_ctrl || paddr == `UUCD_OFF_STATUS ||
                   paddr == `UUCD_OFF_RATE || paddr == `UUCD_OFF_FMT ||
                   paddr == `UUCD_OFF_BREAK || paddr == `UUCD_OFF_LINES;
  wire [31:0] stat_word = {17'h0, ep0_stall, unsafe_wr, ep_halt,
                           remote_wake, configured, 1'b0, dev_addr};
  wire [31:0] rd_mux =
    hit_ctrl                      ? {30'h0, dec_en, self_powered} :
    (paddr == `UUCD_OFF_STATUS)   ? stat_word :
    (paddr == `UUCD_OFF_RATE)     ? lc_rate :
    (paddr == `UUCD_OFF_FMT)      ? {8'h00, lc_bits, lc_parity, lc_stop} :
    (paddr == `UUCD_OFF_BREAK)    ? {16'h0000, brk_len} :
    (paddr == `UUCD_OFF_LINES)    ? {30'h0, rts, dtr} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready       <= 1'b0;
      prdata       <= 32'h0;
      pslverr      <= 1'b0;
      self_powered <= 1'b0;
      dec_en       <= 1'b1;
    end else if (ce) begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !addr_ok;
      end
      if (apb_wr && hit_ctrl) begin
        self_powered <= pwdata[`UUCD_CTRL_SELFPWR];
        dec_en       <= pwdata[`UUCD_CTRL_DEC_EN];
      end
    end
  end
endmodule : uucd_top

// ---- testbench/uucd_properties.sv ----
// checker on the decoder top ports
// assumes ce high and one request in flight at a time
`timescale 1ns/1ps
module uucd_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        setup_valid,
  input wire logic [63:0] setup_pkt,
  input wire logic        half_duplex,
  input wire logic [11:0] reg_rdata,
  input wire logic        in_valid,
  input wire logic [7:0]  in_data,
  input wire logic        ep0_stall,
  input wire logic        xfer_done,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [11:0] reg_wdata,
  input wire logic        dtr,
  input wire logic        rts,
  input wire logic        brk_go,
  input wire logic [15:0] brk_len
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [15:0] rq  = setup_pkt[15:0];
  wire [15:0] val = setup_pkt[31:16];
  wire s_cls = setup_valid && rq == 16'h2221;
  // decoder disable may stall any of these, so stall is an allowed answer
  a_status_answer: assert property (
    setup_valid && rq == 16'h0080 |-> ##2 (in_valid ^ ep0_stall))
    else $error("device status neither answered nor stalled");
  a_lc_length: assert property (
    setup_valid && rq == 16'h2021 && setup_pkt[63:48] != 16'h0007
    |-> ##2 ep0_stall) else $error("bad line coding length not stalled");
  a_break_len: assert property (setup_valid && rq == 16'h2321
    |-> ##2 (ep0_stall || brk_go && brk_len == $past(val, 2)))
    else $error("break not started with its length");
  a_dtr_follow: assert property (
    s_cls |-> ##2 (ep0_stall || dtr == $past(val[0], 2)))
    else $error("terminal ready differs from value bit 0");
  a_rts_follow: assert property (
    s_cls && half_duplex |-> ##2 (ep0_stall || rts == $past(val[1], 2)))
    else $error("request to send differs from value bit 1");
  a_rts_hold: assert property (
    !half_duplex && !$past(half_duplex) |-> $stable(rts))
    else $error("request to send moved in full duplex");
  a_vendor_write: assert property (setup_valid && rq == 16'h0040
    |-> ##2 (ep0_stall || reg_wr && reg_addr == $past(setup_pkt[43:32], 2)
    && reg_wdata == $past(val[11:0], 2)))
    else $error("vendor write address or value wrong");
  a_read_data: assert property (
    reg_rd |-> ##1 (in_valid && in_data == $past(reg_rdata[7:0])))
    else $error("vendor read low byte wrong");
  cover property (xfer_done);
  cover property (reg_rd);
  cover property (brk_go);
endmodule : uucd_properties

bind uucd_top uucd_properties i_uucd_properties (.pclk, .presetn,
  .setup_valid, .setup_pkt, .half_duplex, .reg_rdata, .in_valid, .in_data,
  .ep0_stall, .xfer_done, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .dtr,
  .rts, .brk_go, .brk_len);

// ---- testbench/uucd_host_model.sv ----
// usb host side: one setup, then out bytes, in bytes taken every other cycle
// assumes pkt and pay stay put until the next go
`timescale 1ns/1ps
module uucd_host_model (
  input wire logic        pclk,
  input wire logic        go,
  input wire logic [63:0] pkt,
  input wire logic [55:0] pay,
  input wire logic        in_valid,
  input wire logic [7:0]  in_data,
  output logic            setup_valid,
  output logic [63:0]     setup_pkt,
  output logic            out_valid,
  output logic [7:0]      out_data,
  output logic            in_ready,
  output logic [55:0]     rx
);
  int n = 99;
  logic [55:0] sh;
  initial begin
    {setup_valid, setup_pkt, out_valid, out_data, in_ready, rx} = '0;
  end
  // idle lines show inverted data so stale values never look valid
  always @(posedge pclk) begin
    setup_valid <= go;
    setup_pkt   <= go ? pkt : ~setup_pkt;
    in_ready    <= ~in_ready;
    out_valid   <= 0;
    out_data    <= ~out_data;
    if (in_valid && in_ready) rx <= {in_data, rx[55:8]};
    if (go) begin
      n  <= 0;
      sh <= pay;
    end else begin
      n <= n + 1;
      if (n >= 3 && !pkt[7] && n - 3 < int'(pkt[63:48])) begin
        out_valid <= 1;
        out_data  <= sh[7:0];
        sh        <= sh >> 8;
      end
    end
  end
endmodule : uucd_host_model

// ---- testbench/uucd_top_test.sv ----
// self-checking bench for the control request decoder
// assumes the host model carries setups and payloads
`timescale 1ns/1ps
module uucd_top_test;
  typedef struct {logic [63:0] p; logic s;} uucd_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        go = 0, half_duplex = 1, uart_enabled = 0, e;
  logic        driver_active = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, r;
  logic [63:0] pkt = 0;
  logic [55:0] pay = 0, v;
  logic [11:0] reg_rdata = 12'habc;
  int          error_cnt = 0, cmp_count = 0;
  wire pready, pslverr, setup_valid, out_valid, in_ready, in_valid, dtr, rts;
  wire ep0_stall, xfer_done, desc_req;
  wire [31:0] prdata, lc_rate;
  wire [63:0] setup_pkt;
  wire [55:0] rx;
  wire [7:0]  out_data, in_data, lc_stop, lc_parity, lc_bits;
  wire [55:0] lc = {lc_bits, lc_parity, lc_stop, lc_rate};
  uucd_row_t rows[15] = '{'{64'h0002_0000_0000_0080, 0},
    '{64'h0000_0000_0001_0300, 0}, '{64'h0000_0000_0005_0500, 0},
    '{64'h0000_0000_0001_0900, 0}, '{64'h0000_0000_0002_0900, 1},
    '{64'h0001_0000_0000_0880, 0}, '{64'h0000_0081_0000_0302, 0},
    '{64'h0002_0000_0000_0081, 0}, '{64'h0001_0000_0000_0a81, 0},
    '{64'h0000_0000_0123_2321, 0}, '{64'h0000_0000_0003_2221, 0},
    '{64'h0005_0000_0000_2021, 1}, '{64'h0000_0000_0000_2421, 1},
    '{64'h0000_0400_0002_0300, 0}, '{64'h0012_0000_0100_0680, 0}};
  logic [55:0] bad[3] = '{56'h08050000002580, 56'h08000100002580,
    56'h0a000000002580};
  uucd_top i_uucd_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .setup_valid, .setup_pkt,
    .out_valid, .out_data, .in_ready, .in_valid, .in_data, .ep0_stall,
    .xfer_done, .half_duplex, .driver_active, .uart_enabled, .reg_rdata,
    .reg_wr(), .reg_rd(), .reg_addr(), .reg_wdata(), .dev_addr(),
    .configured(), .remote_wake(), .ep_halt(), .test_go(), .test_sel(),
    .desc_req, .desc_value(), .desc_len(), .dtr, .rts, .brk_go(),
    .brk_len(), .lc_rate, .lc_stop, .lc_parity, .lc_bits, .lc_mirror_load());
  uucd_host_model i_uucd_host_model (.pclk, .go, .pkt, .pay, .in_valid,
    .in_data, .setup_valid, .setup_pkt, .out_valid, .out_data, .in_ready, .rx);
  initial forever #25 pclk = ~pclk;
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic req(input logic [63:0] p, input logic [55:0] y);
    @(posedge pclk);
    pkt <= p;
    pay <= y;
    go  <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (3) @(posedge pclk);
    while (!(xfer_done || ep0_stall || desc_req))
      @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask : req
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge pclk);
    chk(lc, 56'h08000000002580);
    presetn <= 1;
    foreach (rows[i]) begin
      req(rows[i].p, 0);
      chk(ep0_stall, rows[i].s);
    end
    $display("request table done");
    for (int k = 0; k < 5; k++) begin
      v = {8'h08 + 8'(k % 2), 8'(k), 8'h00, 32'h4b0};
      req(64'h0007_0000_0000_2021, v);
      chk(lc, v);
    end
    req(64'h0007_0000_0000_2021, 56'h0704020001c200);
    chk(lc, 56'h0704020001c200);
    foreach (bad[i]) begin
      req(64'h0007_0000_0000_2021, bad[i]);
      chk({ep0_stall, lc}, {1'b1, 56'h0704020001c200});
    end
    req(64'h0007_0000_0000_21a1, 0);
    chk(rx, 56'h0704020001c200);
    $display("line coding done");
    half_duplex <= 0;
    req(64'h0000_0000_0000_2221, 0);
    chk({dtr, rts}, 2'b01);
    half_duplex <= 1;
    req(64'h0000_0000_0000_2221, 0);
    chk(rts, 0);
    $display("control lines done");
    req(64'h0002_0c0e_0000_01c0, 0);
    chk(rx[55:40], 16'h0abc);
    uart_enabled <= 1;
    req(64'h0000_0c0e_0003_0040, 0);
    apb(0, 8'h04, 0);
    chk({e, r[13], r[6:0]}, 9'h005);
    req(64'h0000_0c06_0001_0040, 0);
    apb(0, 8'h04, 0);
    chk(r[13], 1);
    apb(1, 8'h04, 32'h2000);
    apb(0, 8'h04, 0);
    chk(r[13], 0);
    uart_enabled <= 0;
    req(64'h0000_0c06_0000_0040, 0);
    uart_enabled <= 1;
    apb(0, 8'h40, 0);
    chk({e, r}, {1'b1, 32'h0});
    apb(1, 8'h00, 0);
    req(64'h0002_0000_0000_0080, 0);
    chk(ep0_stall, 1);
    apb(1, 8'h00, 32'h2);
    req(64'h0002_0000_0000_0080, 0);
    chk({ep0_stall, rx[55:40]}, 17'h00002);
    $display("register access done");
    test_done;
  end
endmodule : uucd_top_test
